// *** rtl/mode_ctrl_consts.svh ***
// Constants for the antenna mode supervisor
//
// Notes on behaviour
// R1: Exactly one of six operating modes held
// R2: Shutdown brakes on, no power; standby brakes
// R3: Active modes drive axes via their loops
// R4: Remote access acts on bus control messages
// R5: Local access drops control, keeps monitor
// R6: Access mode changes only from local panel
// R7: Shutdown on access change, power-up, reset
// R8: Entry allowed per access mode table
// R9: Faults force stow or shutdown automatically
// R10: Shutdown leaves only to standby, faultless
// R11: Active modes entered only from standby
// R12: Stow reaching position returns to standby
// R13: Remote parameter messages accepted any mode
// R14: Monitor messages always processed
// R15: Command acceptance per operating mode table
// R16: One millisecond reset pulse causes reset
// R17: Never transmit unless polled by master
// R18: Report faults; enter shutdown on them
// R19: Ethernet reset command soft boots unit
// R20: Idle or timing loss stow after timeout; code stows only from standby and shuts down active modes
// R21: Illegal mode request leaves mode unchanged
// R22: Rejected command has no effect at all; code still lets a rejected message restart the idle count
`ifndef MODE_CTRL_CONSTS_SVH
`define MODE_CTRL_CONSTS_SVH
// ------
// Register offsets (byte addresses)
// ------
`define REG_CTRL 8'h00
`define REG_MSG 8'h04
`define REG_STATUS 8'h08
`define REG_IDLE_TIME 8'h0c
`define REG_FAULTS 8'h10
`define REG_TRAJ 8'h14
// ------
// Field positions and widths
// ------
`define CTRL_PANEL_REQ 0
`define CTRL_PANEL_REM 1
`define CTRL_PANEL_MODE 4
`define CTRL_ETH_RESET 8
`define CTRL_POLL 9
`define MSG_KIND_LSB 0
`define MSG_MODE_LSB 4
`define MODE_W 3
`define KIND_W 3
`define FAULT_W 6
`define IDLE_RESET 16'h003c
// ------
// Timing
// ------
`define CLK_HZ 50000000
`define RST_PULSE_US 1000
`define RST_PULSE_CYC ((`RST_PULSE_US * (`CLK_HZ / 1000000)))
`define CYC_PER_SEC `CLK_HZ
`endif

// *** rtl/mode_ctrl_pkg.sv ***
// Types for the antenna mode supervisor
package mode_ctrl_pkg;
  // Operating modes, one held at a time
  typedef enum logic [2:0] {
    M_SHUTDOWN = 3'h0,
    M_STANDBY  = 3'h1,
    M_VELOCITY = 3'h2,
    M_ENCODER  = 3'h3,
    M_AUTO     = 3'h4,
    M_STOW     = 3'h5
  } op_mode_t;
  // Message classes arriving from the bus
  typedef enum logic [2:0] {
    K_MONITOR  = 3'h0,
    K_SET      = 3'h1,
    K_MODE     = 3'h2,
    K_RESET    = 3'h3,
    K_AZ_TRAJ  = 3'h4,
    K_EL_TRAJ  = 3'h5
  } msg_kind_t;
endpackage : mode_ctrl_pkg

// *** rtl/antenna_mode_controller.sv ***
// AXI4-Lite mode supervisor for the antenna control unit
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "mode_ctrl_consts.svh"

module antenna_mode_controller
  import mode_ctrl_pkg::*;
#(
  parameter int unsigned RST_PULSE_CYCLES = `RST_PULSE_CYC,
  parameter int unsigned CYCLES_PER_SEC   = `CYC_PER_SEC
) (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Pins from the field
  input  wire logic        bus_reset_pin,
  input  wire logic        timing_pulse,
  input  wire logic [5:0]  fault_in,
  input  wire logic        stow_reached,
  // Drive outputs
  output logic             brake_on,
  output logic             motor_power,
  output logic             drive_ready,
  output logic [2:0]       drive_loop,
  output logic             tx_enable,
  output logic             soft_boot
);

  // ------
  // Helper functions
  // ------
  // Entry legality under an access mode, from a given mode
  function automatic logic mode_ok(input op_mode_t cur, req,
    input logic remote, fault);
    logic ok;
    ok = 1'b0;
    case (req)
      M_SHUTDOWN: ok = 1'b1;
      M_STANDBY:  ok = (cur != M_SHUTDOWN) || !fault; // R10
      M_VELOCITY: ok = !remote && (cur == M_STANDBY); // R8 R11
      M_ENCODER:  ok = (cur == M_STANDBY);            // R11
      M_AUTO:     ok = remote && (cur == M_STANDBY);  // R8 R11
      M_STOW:     ok = (cur == M_STANDBY);            // R11
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction : mode_ok

  // Command acceptance per operating mode in remote access
  function automatic logic cmd_ok(input op_mode_t cur, input msg_kind_t k,
    input logic remote);
    logic ok;
    ok = 1'b0;
    case (k)
      K_MONITOR: ok = 1'b1;                          // R14
      K_SET:     ok = remote;                        // R13 R5
      K_MODE,
      K_RESET:   ok = remote && cur != M_VELOCITY;   // R15 R5
      K_AZ_TRAJ,
      K_EL_TRAJ: ok = remote &&
                      (cur == M_ENCODER || cur == M_AUTO); // R15
      default:   ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_ok

  // ------
  // Pin synchronisers
  // ------
  logic [2:0] rst_sync_q;   // Reset pin, three stages
  logic [2:0] tp_sync_q;    // Timing pulse, three stages
  logic       rst_lvl_q;    // Agreed reset pin level
  logic       tp_lvl_q;     // Agreed timing pulse level

  // Change counts only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_sync_q <= 3'h0;
      tp_sync_q  <= 3'h0;
      rst_lvl_q  <= 1'b0;
      tp_lvl_q   <= 1'b0;
    end else if (clk_en) begin
      rst_sync_q <= {rst_sync_q[1:0], bus_reset_pin};
      tp_sync_q  <= {tp_sync_q[1:0], timing_pulse};
      if (rst_sync_q[1] == rst_sync_q[2]) begin
        rst_lvl_q <= rst_sync_q[2];
      end
      if (tp_sync_q[1] == tp_sync_q[2]) begin
        tp_lvl_q <= tp_sync_q[2];
      end
    end
  end

  // ------
  // Bus reset pulse measurement
  // ------
  logic [31:0] pulse_cnt_q; // High-time counter
  logic        pin_reset;   // Pulse long enough seen

  // Counts the high time; fires once at the threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_q <= 32'h0;
    end else if (clk_en) begin
      if (!rst_lvl_q) begin
        pulse_cnt_q <= 32'h0;
      end else if (pulse_cnt_q != RST_PULSE_CYCLES[31:0]) begin
        pulse_cnt_q <= pulse_cnt_q + 32'h1;
      end
    end
  end
  // Pulse measured a full 1 ms acts once
  assign pin_reset = rst_lvl_q &&
                     (pulse_cnt_q == RST_PULSE_CYCLES[31:0] - 32'h1); // R16

  // ------
  // AXI4-Lite slave
  // ------
  logic        aw_q, w_q;   // Latched address / data held
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;       // Both halves present
  logic [15:0] idle_time_q; // Idle stow timeout, seconds
  logic        eth_reset_q; // Debug reset request pulse
  logic        poll_q;      // Master poll pulse
  logic        panel_q;     // Panel request pulse
  logic        panel_rem_q; // Panel access choice
  op_mode_t    panel_mode_q;// Panel mode request
  logic        msg_q;       // Bus message pulse
  msg_kind_t   msg_kind_q;
  op_mode_t    msg_mode_q;
  logic        wr_bad;

  assign wr_go  = aw_q && w_q && !s_axi_bvalid;
  assign wr_bad = !(awaddr_q == `REG_CTRL || awaddr_q == `REG_MSG ||
                    awaddr_q == `REG_IDLE_TIME);

  // Write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 8'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_bad ? 2'h2 : 2'h0; // SLVERR on unmapped
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; message and panel writes are one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_time_q  <= `IDLE_RESET;
      eth_reset_q  <= 1'b0;
      poll_q       <= 1'b0;
      panel_q      <= 1'b0;
      panel_rem_q  <= 1'b0;
      panel_mode_q <= M_SHUTDOWN;
      msg_q        <= 1'b0;
      msg_kind_q   <= K_MONITOR;
      msg_mode_q   <= M_SHUTDOWN;
    end else if (clk_en) begin
      eth_reset_q <= 1'b0;
      poll_q      <= 1'b0;
      panel_q     <= 1'b0;
      msg_q       <= 1'b0;
      if (wr_go && wstrb_q[0] && awaddr_q == `REG_CTRL) begin
        panel_q      <= wdata_q[`CTRL_PANEL_REQ];
        panel_rem_q  <= wdata_q[`CTRL_PANEL_REM];
        panel_mode_q <= op_mode_t'(wdata_q[`CTRL_PANEL_MODE +: 3]);
      end
      if (wr_go && wstrb_q[1] && awaddr_q == `REG_CTRL) begin
        eth_reset_q <= wdata_q[`CTRL_ETH_RESET]; // R19
        poll_q      <= wdata_q[`CTRL_POLL];
      end
      if (wr_go && wstrb_q[0] && awaddr_q == `REG_MSG) begin
        msg_q      <= 1'b1;
        msg_kind_q <= msg_kind_t'(wdata_q[`MSG_KIND_LSB +: 3]);
        msg_mode_q <= op_mode_t'(wdata_q[`MSG_MODE_LSB +: 3]);
      end
      if (wr_go && awaddr_q == `REG_IDLE_TIME) begin
        if (wstrb_q[0]) idle_time_q[7:0]  <= wdata_q[7:0];
        if (wstrb_q[1]) idle_time_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // ------
  // Mode supervisor
  // ------
  op_mode_t    mode_q;       // Operating mode, single state
  logic        remote_q;     // Access mode: 1 remote, 0 local
  logic        fault;        // Any fault present
  logic        accept;       // Message accepted now
  logic        do_reset;     // Software reset from any source
  logic        idle_stow;    // Communication timeout
  logic [31:0] sec_cnt_q;    // Cycles within a second
  logic [15:0] idle_sec_q;   // Seconds without traffic
  logic        tp_prev_q;
  logic        tp_hit_q;     // Timing edge since restart
  logic        traj_seen_q;  // Trajectory accepted
  logic [5:0]  fault_seen_q; // Fault report, copy of fault_in each cycle

  assign fault  = |fault_in;
  assign accept = msg_q && cmd_ok(mode_q, msg_kind_q, remote_q); // R22
  assign do_reset = pin_reset || eth_reset_q ||
                    (accept && msg_kind_q == K_RESET);
  assign idle_stow = (idle_sec_q >= idle_time_q) && idle_time_q != 16'h0;

  // Seconds since last bus message that followed a timing edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_q  <= 32'h0;
      idle_sec_q <= 16'h0;
      tp_prev_q  <= 1'b0;
      tp_hit_q   <= 1'b0;
    end else if (clk_en) begin
      tp_prev_q <= tp_lvl_q;
      // Restart needs traffic and a timing edge; either one going
      // quiet lets the count run out
      if (msg_q && tp_hit_q) begin
        sec_cnt_q  <= 32'h0;
        idle_sec_q <= 16'h0;
        tp_hit_q   <= 1'b0;
      end else if (sec_cnt_q == CYCLES_PER_SEC[31:0] - 32'h1) begin
        sec_cnt_q <= 32'h0;
        if (idle_sec_q != 16'hffff) idle_sec_q <= idle_sec_q + 16'h1; // R20
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h1;
      end
      if (tp_lvl_q && !tp_prev_q) tp_hit_q <= 1'b1; // R20
    end
  end

  // Access mode: only the panel changes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_q <= 1'b0;
    end else if (clk_en && panel_q) begin
      remote_q <= panel_rem_q; // R6
    end
  end

  // Operating mode transitions, highest priority first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= M_SHUTDOWN; // R7
    end else if (clk_en) begin
      if (do_reset) begin
        mode_q <= M_SHUTDOWN; // R7 R16
      end else if (panel_q && panel_rem_q != remote_q) begin
        mode_q <= M_SHUTDOWN; // R7
      end else if (fault) begin
        mode_q <= M_SHUTDOWN; // R9 R18
      end else if (idle_stow && mode_q != M_SHUTDOWN &&
                   mode_q != M_STOW) begin
        mode_q <= (mode_q == M_STANDBY) ? M_STOW : M_SHUTDOWN; // R9 R20
      end else if (mode_q == M_STOW && stow_reached) begin
        mode_q <= M_STANDBY; // R12
      end else if (panel_q && !remote_q &&
                   mode_ok(mode_q, panel_mode_q, 1'b0, fault)) begin
        mode_q <= panel_mode_q; // R8
      end else if (accept && msg_kind_q == K_MODE &&
                   mode_ok(mode_q, msg_mode_q, 1'b1, fault)) begin
        mode_q <= msg_mode_q; // R4 R21
      end
    end
  end

  // Trajectory acceptance and fault report
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      traj_seen_q  <= 1'b0;
      fault_seen_q <= 6'h0;
    end else if (clk_en) begin
      if (accept && (msg_kind_q == K_AZ_TRAJ ||
                     msg_kind_q == K_EL_TRAJ)) begin
        traj_seen_q <= 1'b1; // R15
      end else if (mode_q != M_ENCODER && mode_q != M_AUTO) begin
        traj_seen_q <= 1'b0;
      end
      fault_seen_q <= fault_in; // R18
    end
  end

  // ------
  // Drive outputs
  // ------
  // Brakes, power and loop selection follow the mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brake_on    <= 1'b1;
      motor_power <= 1'b0;
      drive_ready <= 1'b0;
      drive_loop  <= 3'h0;
      tx_enable   <= 1'b0;
      soft_boot   <= 1'b0;
    end else if (clk_en) begin
      brake_on    <= (mode_q == M_SHUTDOWN || mode_q == M_STANDBY); // R2
      motor_power <= (mode_q != M_SHUTDOWN);                       // R2
      drive_ready <= (mode_q != M_SHUTDOWN);
      drive_loop  <= (mode_q == M_SHUTDOWN || mode_q == M_STANDBY) ?
                     3'h0 : mode_q; // R3 R1
      tx_enable   <= poll_q; // R17
      soft_boot   <= do_reset; // R19
    end
  end

  // ------
  // Read channel
  // ------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    case ({s_axi_araddr[7:2], 2'h0})
      `REG_CTRL:      rd_word = {31'h0, remote_q};
      `REG_STATUS:    rd_word = {24'h0, traj_seen_q, idle_stow,
                                 fault, remote_q, 1'b0, mode_q};
      `REG_IDLE_TIME: rd_word = {16'h0, idle_time_q};
      `REG_FAULTS:    rd_word = {26'h0, fault_seen_q};
      default:        rd_word = 32'h0;
    endcase
  end

  // One read at a time; answer the cycle after arready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (s_axi_araddr[7:2] > 6'h4 ||
                         s_axi_araddr[7:2] == 6'h1) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : antenna_mode_controller

// *** sim/mode_ctrl_monitor.sv ***
// Port-level checker for the antenna mode supervisor
`timescale 1ns/1ps
module mode_ctrl_monitor #(
  parameter int unsigned RST_PULSE_CYCLES = 8
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  // Field side
  input wire logic        bus_reset_pin,
  input wire logic [5:0]  fault_in,
  // Drive outputs
  input wire logic        brake_on,
  input wire logic        motor_power,
  input wire logic [2:0]  drive_loop,
  input wire logic        tx_enable,
  input wire logic        soft_boot
);
  // ------
  // Helpers
  // ------
  int unsigned hi_q;   // Cycles the reset pin has been high
  logic        boot_q; // Boot seen in this high stretch
  logic [3:0]  poll_q; // Cycles since last poll write
  // Saturating length of the pin's high stretch
  always_ff @(posedge aclk) begin
    if (!bus_reset_pin) hi_q <= 0;
    else if (hi_q < 255) hi_q <= hi_q + 1;
  end
  // Remember a boot while the pin stays high
  always_ff @(posedge aclk) begin
    if (!bus_reset_pin) boot_q <= 1'b0;
    else if (soft_boot) boot_q <= 1'b1;
  end
  // Age of the last poll; saturates so it never wraps to young
  always_ff @(posedge aclk) begin
    if (!aresetn) poll_q <= 4'hf;
    else if (s_axi_wvalid && s_axi_wready && s_axi_wdata[9]) poll_q <= 4'h0;
    else if (poll_q != 4'hf) poll_q <= poll_q + 4'h1;
  end
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_reset_safe: assert property (disable iff (1'b0)
    !aresetn |=> brake_on && !motor_power && drive_loop == 3'h0)
    else $error("outputs not safe after reset");
  chk_loop_legal: assert property (
    drive_loop != 3'h1 && drive_loop <= 3'h5)
    else $error("drive loop code outside mode set");
  chk_idle_brake: assert property (drive_loop == 3'h0 |-> brake_on)
    else $error("brake released while idle");
  chk_fault_stop: assert property (
    (fault_in != 6'h0)[*6] |-> drive_loop == 3'h0 && !motor_power)
    else $error("fault did not stop the drive");
  chk_boot_pulse: assert property (soft_boot |=> !soft_boot)
    else $error("boot pulse longer than one cycle");
  chk_boot_pin: assert property (hi_q == RST_PULSE_CYCLES + 6 |-> boot_q)
    else $error("long reset pulse gave no boot");
  chk_tx_polled: assert property (tx_enable |-> poll_q < 4'h6)
    else $error("transmit without poll");
  chk_tx_single: assert property (tx_enable |=> !tx_enable)
    else $error("transmit enable longer than one cycle");
  chk_read_answer: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (
    s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
endmodule : mode_ctrl_monitor

bind antenna_mode_controller mode_ctrl_monitor #(
  .RST_PULSE_CYCLES(RST_PULSE_CYCLES)
) mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .bus_reset_pin(bus_reset_pin),
  .fault_in(fault_in), .brake_on(brake_on), .motor_power(motor_power),
  .drive_loop(drive_loop), .tx_enable(tx_enable), .soft_boot(soft_boot));

// *** sim/field_side_model.sv ***
// Far-side model: master reset pulse, timing pulse, stow sensor
`timescale 1ns/1ps
module field_side_model (
  // Clock and bench commands
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] plen,
  input  wire logic       park,
  // Lines into the unit
  output logic            bus_reset_pin,
  output logic            timing_pulse,
  output logic            stow_reached
);
  logic [7:0] left_q = 8'h0; // Pulse cycles still to drive
  logic [2:0] tick_q = 3'h0; // Timing pulse divider
  logic [3:0] slow_q = 4'h0; // Slow stow sensor settling
  // Master holds the pin high for exactly plen cycles
  always_ff @(posedge aclk) begin
    if (go) left_q <= plen;
    else if (left_q != 8'h0) left_q <= left_q - 8'h1;
  end
  // Free running timing pulse, kept alive so no loss is seen
  always_ff @(posedge aclk) begin
    tick_q <= tick_q + 3'h1;
  end
  // Sensor lags the axes by a few cycles
  always_ff @(posedge aclk) begin
    slow_q <= {slow_q[2:0], park};
  end
  assign bus_reset_pin = (left_q != 8'h0);
  assign timing_pulse  = tick_q[2];
  assign stow_reached  = slow_q[3];
endmodule : field_side_model

// *** sim/antenna_mode_controller_bench.sv ***
// Self-checking bench for the antenna mode supervisor
`timescale 1ns/1ps
`include "mode_ctrl_consts.svh"
module antenna_mode_controller_bench import mode_ctrl_pkg::*; ();
  // ------
  // Signals
  // ------
  logic        aclk, aresetn; // Clock, reset
  logic        awvalid, awready, wvalid, wready; // Write request
  logic        bvalid, bready, arvalid, arready; // Answer, read
  logic        rvalid, rready; // Read answer
  logic [7:0]  awaddr, araddr, plen; // Addresses, pin pulse length
  logic [31:0] wdata, rdata, d; // Data
  logic [1:0]  bresp, rresp, r; // Responses
  logic [3:0]  wstrb; // Byte lanes
  logic [5:0]  fault_in; // Fault bits
  logic        pin, tpulse, at_stow, park, go, acc; // Field side
  logic        brake_on, motor_power, drive_ready; // Drive levels
  logic        tx_enable, soft_boot; // Pulses
  logic [2:0]  drive_loop; // Loop code
  op_mode_t    cur, q; // Expected and requested mode
  int          bad_count, tests_run; // Tallies
  int          tx_n = 0, boot_n = 0; // Pulse counts
  // Short counts keep the run brief
  antenna_mode_controller #(.RST_PULSE_CYCLES(8), .CYCLES_PER_SEC(10)) uut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .bus_reset_pin(pin),
    .timing_pulse(tpulse), .fault_in(fault_in), .stow_reached(at_stow),
    .brake_on(brake_on), .motor_power(motor_power), .drive_ready(drive_ready),
    .drive_loop(drive_loop), .tx_enable(tx_enable), .soft_boot(soft_boot));
  field_side_model far (.aclk(aclk), .go(go), .plen(plen), .park(park),
    .bus_reset_pin(pin), .timing_pulse(tpulse), .stow_reached(at_stow));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Count the one-cycle pulses
  always @(posedge aclk) begin
    if (tx_enable === 1'b1) tx_n <= tx_n + 1;
    if (soft_boot === 1'b1) boot_n <= boot_n + 1;
  end
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [31:0] got, exp, input string s);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic hang;
    bad_count++;
    finish_test();
  endtask : hang
  // Write; each half released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 64) hang();
    repeat (3) @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 64) hang();
    @(posedge aclk);
  endtask : rd
  task automatic see(input op_mode_t m, input string s);
    rd(`REG_STATUS);
    chk(d[2:0], m, s);
  endtask : see
  // Mode request through the source that the access mode honours
  task automatic ask(input op_mode_t m);
    if (acc) wr(`REG_MSG, {25'h0, m, 4'h2});
    else wr(`REG_CTRL, {25'h0, m, 4'h1});
  endtask : ask
  task automatic access(input logic a);
    wr(`REG_CTRL, {30'h0, a, 1'b1});
    acc = a;
  endtask : access
  task automatic pulse(input logic [7:0] n);
    plen <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (40) @(posedge aclk);
  endtask : pulse
  // Expected mode after a request, no fault present
  function automatic op_mode_t nxt(op_mode_t c, op_mode_t m, logic rem);
    nxt = c;
    if (m == M_SHUTDOWN) nxt = M_SHUTDOWN;
    else if (c == M_SHUTDOWN) begin
      if (m == M_STANDBY) nxt = M_STANDBY;
    end
    else if (c == M_STANDBY) begin
      if (m == M_VELOCITY && !rem) nxt = m;
      if (m == M_AUTO && rem) nxt = m;
      if (m == M_ENCODER || m == M_STOW) nxt = m;
    end
  endfunction : nxt
  // ------
  // Main sequence
  // ------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, park} = '0;
    {awaddr, araddr, wdata, plen, fault_in} = '0;
    wstrb = 4'hf;
    acc = 1'b0;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(32'hdb9c3745));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    see(M_SHUTDOWN, "mode at reset");
    chk(d[4], 1'b0, "local at reset");
    chk(brake_on, 1'b1, "brake at reset");
    rd(`REG_IDLE_TIME);
    chk(d[15:0], 16'h003c, "idle time reset value");
    wr(`REG_IDLE_TIME, 32'h0);
    rd(8'h20);
    chk(r, 2'b10, "unmapped read");
    wr(8'h18, 32'h0);
    chk(r, 2'b10, "unmapped write");
    chk(tx_n, 0, "no transmit unpolled");
    wr(`REG_CTRL, 32'h200);
    chk(tx_n, 1, "transmit after poll");
    $display("test done: reset and poll");
    for (int i = 0; i < 12; i++) begin
      q = op_mode_t'($urandom % 6);
      access(1'($urandom));
      see(M_SHUTDOWN, "access change");
      chk(d[4], acc, "access follows panel");
      if (acc) wr(`REG_CTRL, {25'h0, M_STANDBY, 4'h3});
      else wr(`REG_MSG, {25'h0, M_STANDBY, 4'h2});
      see(M_SHUTDOWN, "request from ignored source");
      chk(d[4], acc, "message keeps access");
      ask(q);
      cur = nxt(M_SHUTDOWN, q, acc);
      see(cur, "request from shutdown");
      ask(M_STANDBY);
      see(M_STANDBY, "enter standby");
      chk(drive_ready, 1'b1, "ready in standby");
      ask(q);
      cur = nxt(M_STANDBY, q, acc);
      see(cur, "request from standby");
      q = op_mode_t'(2 + $urandom % 4);
      ask(q);
      cur = nxt(cur, q, acc);
      see(cur, "second active request");
      ask(M_SHUTDOWN);
      see(M_SHUTDOWN, "back to shutdown");
    end
    $display("test done: random transitions");
    access(1'b1);
    ask(M_STANDBY);
    fault_in <= 6'(1 << ($urandom % 6));
    repeat (8) @(posedge aclk);
    see(M_SHUTDOWN, "fault stops unit");
    chk(d[5], 1'b1, "fault reported");
    ask(M_STANDBY);
    see(M_SHUTDOWN, "standby refused under fault");
    fault_in <= 6'h0;
    repeat (8) @(posedge aclk);
    ask(M_STANDBY);
    see(M_STANDBY, "standby after fault clears");
    $display("test done: faults");
    wr(`REG_MSG, 32'h4);
    see(M_STANDBY, "trajectory in standby");
    chk(d[7], 1'b0, "trajectory refused");
    ask(M_ENCODER);
    wr(`REG_MSG, 32'h5);
    see(M_ENCODER, "trajectory in encoder");
    chk(d[7], 1'b1, "trajectory taken");
    ask(M_SHUTDOWN);
    ask(M_STANDBY);
    ask(M_STOW);
    see(M_STOW, "stow entered");
    park <= 1'b1;
    repeat (12) @(posedge aclk);
    see(M_STANDBY, "stow reached");
    park <= 1'b0;
    $display("test done: trajectory and stow");
    wr(`REG_IDLE_TIME, 32'h1);
    repeat (40) @(posedge aclk);
    see(M_STOW, "idle timeout stows");
    wr(`REG_IDLE_TIME, 32'h0);
    ask(M_SHUTDOWN);
    ask(M_STANDBY);
    wr(`REG_MSG, 32'h3);
    see(M_SHUTDOWN, "reset message");
    chk(boot_n, 1, "boot on reset message");
    access(1'b1);
    ask(M_STANDBY);
    wr(`REG_CTRL, 32'h102);
    see(M_SHUTDOWN, "debug reset");
    chk(boot_n, 2, "boot on debug reset");
    pulse(8'd4);
    chk(boot_n, 2, "short pin pulse ignored");
    pulse(8'd20);
    chk(boot_n, 3, "long pin pulse boots");
    $display("test done: idle and resets");
    finish_test();
  end
endmodule : antenna_mode_controller_bench
